// File: src/tmrfd_cfg.svh
`ifndef TMRFD_CFG_SVH
`define TMRFD_CFG_SVH

// Timing, in ns or us as printed
`define TMRFD_CLK_NS        25
`define TMRFD_SLOT_NS       4000
`define TMRFD_DAC1V_NS      1000
`define TMRFD_DAC4V_NS      4000
`define TMRFD_SETTLE_NS     1000
`define TMRFD_TICK_US       250

// Derived cycle counts, least times rounded up
`define TMRFD_CEIL_CYC(ns)  (((ns) + `TMRFD_CLK_NS - 1) / `TMRFD_CLK_NS)
`define TMRFD_SLOT_CYC      `TMRFD_CEIL_CYC(`TMRFD_SLOT_NS)
`define TMRFD_DAC1V_CYC     `TMRFD_CEIL_CYC(`TMRFD_DAC1V_NS)
`define TMRFD_DAC4V_CYC     `TMRFD_CEIL_CYC(`TMRFD_DAC4V_NS)
`define TMRFD_SETTLE_CYC    `TMRFD_CEIL_CYC(`TMRFD_SETTLE_NS)
`define TMRFD_TICK_CYC      ((`TMRFD_TICK_US * 1000) / `TMRFD_CLK_NS)

// Register byte offsets
`define TMRFD_A_CTRL        8'h00
`define TMRFD_A_FLEN        8'h04
`define TMRFD_A_RAILEN      8'h08
`define TMRFD_A_STATUS      8'h0c
`define TMRFD_A_ISTAT       8'h10
`define TMRFD_A_IMASK       8'h14
`define TMRFD_A_THR0        8'h20
`define TMRFD_A_THR3        8'h2c

// Reset values
`define TMRFD_RST_CTRL      7'h1e
`define TMRFD_RST_FLEN      4'h8

// Interrupt status layout
`define TMRFD_IRQ_TICK      4

// AXI responses
`define TMRFD_RESP_OKAY     2'h0
`define TMRFD_RESP_SLVERR   2'h2

`endif

// File: src/tmrfd_pkg.sv
package tmrfd_pkg;

  // Control register: run, compare enables, DAC range, rail count - 1
  typedef struct packed {
    logic [1:0] last_rail;
    logic       range_4v;
    logic       uv_en;
    logic       ov_en;
    logic       run;
    logic       spare;
  } tmrfd_ctrl_s;

  // Per-rail glitch filter history
  typedef struct packed {
    logic [3:0] ov_cnt;
    logic [3:0] uv_cnt;
    logic       ov_flt;
    logic       uv_flt;
  } tmrfd_filt_s;

  // Per-rail threshold DAC codes
  typedef struct packed {
    logic [7:0] ov_code;
    logic [7:0] uv_code;
  } tmrfd_thr_s;

  // Slot sequence
  typedef enum logic [3:0] {
    ST_IDLE, ST_SELECT, ST_LOAD, ST_RESTORE, ST_SETTLE,
    ST_SAMPLE, ST_SAVE, ST_DISC, ST_WAIT
  } tmrfd_state_e;

endpackage : tmrfd_pkg

// File: src/tmrfd_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "tmrfd_cfg.svh"

module tmrfd_top
  import tmrfd_pkg::*;
#(
  parameter int TICK_CYC = `TMRFD_TICK_CYC
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // AXI4-Lite write channels
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Analog comparator results, asynchronous
  input  wire logic        cmp_ov,
  input  wire logic        cmp_uv,
  // Input mux and threshold DACs
  output logic             mux_en,
  output logic [1:0]       mux_sel,
  output logic [7:0]       dac_uv,
  output logic [7:0]       dac_ov,
  output logic             dac_load,
  // Rail control and health
  output logic [3:0]       rail_en,
  output logic [3:0]       pgood,
  output logic [3:0]       fault_uv,
  output logic [3:0]       fault_ov,
  output logic             irq
);

  // Fixed cycle counts
  localparam logic [7:0]  SLOT_CYC   = 8'(`TMRFD_SLOT_CYC);
  localparam logic [7:0]  DAC1V_CYC  = 8'(`TMRFD_DAC1V_CYC);
  localparam logic [7:0]  DAC4V_CYC  = 8'(`TMRFD_DAC4V_CYC);
  localparam logic [7:0]  SETTLE_CYC = 8'(`TMRFD_SETTLE_CYC);
  localparam logic [15:0] TICK_LAST  = 16'(TICK_CYC - 1);

  // Saturating increment, shared by both filter halves
  function automatic logic [3:0] sat_inc(input logic [3:0] v);
    sat_inc = (v == 4'hf) ? v : v + 4'h1;
  endfunction : sat_inc

  // One filter half: count run of out-of-window samples
  function automatic logic [4:0] filt_step(input logic       hit,
                                           input logic [3:0] cnt,
                                           input logic [3:0] len);
    logic [3:0] c;
    c = hit ? sat_inc(cnt) : 4'h0;
    filt_step = {c, (c >= len) && (len != 4'h0)};
  endfunction : filt_step

  // Register file
  tmrfd_ctrl_s  ctrl_r;                  // Control
  logic [3:0]   flen_r;                  // Glitch filter length
  logic [4:0]   istat_r;                 // Sticky events
  logic [4:0]   imask_r;                 // Event mask
  tmrfd_thr_s   thr_mem [4];             // Threshold memory per rail
  tmrfd_filt_s  filt_mem [4];            // Saved filter history per rail

  // Sequencer state
  tmrfd_state_e state_r;
  logic [1:0]   idx_r;                   // Rail being visited
  logic [7:0]   cnt_r;                   // Settle counter
  logic [7:0]   slot_r;                  // Slot-length counter
  tmrfd_filt_s  filt_r;                  // Working filter copy
  logic [15:0]  tick_r;                  // Service-tick divider

  // Comparator synchronisers
  logic [1:0]   ov_meta_r;
  logic [1:0]   uv_meta_r;
  logic         ov_s;
  logic         uv_s;

  // Bus slave state
  logic         aw_got_r;
  logic         w_got_r;
  logic [7:0]   aw_addr_r;
  logic [31:0]  w_data_r;
  logic [3:0]   w_strb_r;
  logic         wr_go;
  logic [31:0]  rd_val;
  logic         rd_hit;
  logic         wr_hit;
  logic [31:0]  wmask;

  // Events of this cycle
  logic [3:0]   flt_evt;
  logic         tick_evt;
  logic [7:0]   slot_len;

  // Outputs other than the bus ready signals are all flops
  logic         mux_en_r, dac_load_r, irq_r;
  logic [1:0]   mux_sel_r;
  logic [7:0]   dac_uv_r, dac_ov_r;
  logic [3:0]   rail_en_r, pgood_r, fault_uv_r, fault_ov_r;

  // Two flops before any logic reads the comparator
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ov_meta_r <= 2'h0;
      uv_meta_r <= 2'h0;
    end else begin
      ov_meta_r <= {ov_meta_r[0], cmp_ov};
      uv_meta_r <= {uv_meta_r[0], cmp_uv};
    end
  end
  assign ov_s = ov_meta_r[1];
  assign uv_s = uv_meta_r[1];

  // Slot cannot be shorter than the DAC update period
  assign slot_len = ctrl_r.range_4v
                    ? ((DAC4V_CYC > SLOT_CYC) ? DAC4V_CYC : SLOT_CYC)
                    : ((DAC1V_CYC > SLOT_CYC) ? DAC1V_CYC : SLOT_CYC);

  // Slot sequencer; no processor action needed once run is set
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_r <= ST_IDLE;
      idx_r   <= 2'h0;
      cnt_r   <= 8'h0;
      slot_r  <= 8'h0;
    end else begin
      slot_r <= (state_r == ST_IDLE) ? 8'h0 : slot_r + 8'h1;
      case (state_r)
        ST_IDLE: begin
          idx_r <= 2'h0;
          if (ctrl_r.run) begin
            state_r <= ST_SELECT;
          end
        end
        ST_SELECT: begin
          slot_r  <= 8'h1;
          state_r <= ST_LOAD;
        end
        ST_LOAD:    state_r <= ST_RESTORE;
        ST_RESTORE: begin
          cnt_r   <= 8'h0;
          state_r <= ST_SETTLE;
        end
        ST_SETTLE: begin
          // Comparator path includes two sync flops; settle covers them
          cnt_r <= cnt_r + 8'h1;
          if (cnt_r == SETTLE_CYC - 8'h1) begin
            state_r <= ST_SAMPLE;
          end
        end
        ST_SAMPLE:  state_r <= ST_SAVE;
        ST_SAVE:    state_r <= ST_DISC;
        ST_DISC:    state_r <= ST_WAIT;
        ST_WAIT: begin
          if (slot_r >= slot_len - 8'h1) begin
            // Wrap after the configured last rail
            idx_r   <= (idx_r >= ctrl_r.last_rail) ? 2'h0 : idx_r + 2'h1;
            state_r <= ctrl_r.run ? ST_SELECT : ST_IDLE;
          end
        end
        default:    state_r <= ST_IDLE;
      endcase
    end
  end

  // Input mux: on from select to disconnect
  always_ff @(posedge core_clk) begin
    if (srst) begin
      mux_en_r  <= 1'b0;
      mux_sel_r <= 2'h0;
    end else if (state_r == ST_SELECT) begin
      mux_en_r  <= 1'b1;
      mux_sel_r <= idx_r;
    end else if (state_r == ST_DISC || state_r == ST_IDLE) begin
      mux_en_r  <= 1'b0;
    end
  end

  // Threshold transfer from memory to DACs
  always_ff @(posedge core_clk) begin
    if (srst) begin
      dac_uv_r   <= 8'h0;
      dac_ov_r   <= 8'h0;
      dac_load_r <= 1'b0;
    end else begin
      dac_load_r <= (state_r == ST_LOAD);
      if (state_r == ST_LOAD) begin
        dac_uv_r <= thr_mem[idx_r].uv_code;
        dac_ov_r <= thr_mem[idx_r].ov_code;
      end
    end
  end

  // Working filter: restore, sample, then written back
  always_ff @(posedge core_clk) begin
    if (srst) begin
      filt_r <= '0;
    end else if (state_r == ST_RESTORE) begin
      filt_r <= filt_mem[idx_r];
    end else if (state_r == ST_SAMPLE) begin
      {filt_r.ov_cnt, filt_r.ov_flt} <= filt_step(ov_s & ctrl_r.ov_en,
                                                  filt_r.ov_cnt, flen_r);
      {filt_r.uv_cnt, filt_r.uv_flt} <= filt_step(uv_s & ctrl_r.uv_en,
                                                  filt_r.uv_cnt, flen_r);
    end
  end

  // Save-back and per-rail fault flags
  always_ff @(posedge core_clk) begin
    if (srst) begin
      for (int i = 0; i < 4; i++) begin
        filt_mem[i] <= '0;
      end
      fault_uv_r <= 4'h0;
      fault_ov_r <= 4'h0;
    end else if (state_r == ST_SAVE) begin
      filt_mem[idx_r]   <= filt_r;
      fault_uv_r[idx_r] <= filt_r.uv_flt;
      fault_ov_r[idx_r] <= filt_r.ov_flt;
    end
  end

  // New fault on a rail, seen at save time
  always_comb begin
    flt_evt = 4'h0;
    if (state_r == ST_SAVE) begin
      flt_evt[idx_r] = (filt_r.uv_flt | filt_r.ov_flt)
                       & ~(fault_uv_r[idx_r] | fault_ov_r[idx_r]);
    end
  end

  // Power-good low while a fault stands; rail cut one cycle later
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pgood_r <= 4'h0;
    end else begin
      pgood_r <= ~(fault_uv_r | fault_ov_r);
    end
  end

  // Rail enables: software sets, hardware clears a rail that lost power-good
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rail_en_r <= 4'h0;
    end else if (wr_go && aw_addr_r == `TMRFD_A_RAILEN && w_strb_r[0]) begin
      rail_en_r <= w_data_r[3:0] & pgood_r;
    end else begin
      rail_en_r <= rail_en_r & pgood_r;
    end
  end

  // Periodic service tick
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tick_r <= 16'h0;
    end else begin
      tick_r <= (tick_r == TICK_LAST) ? 16'h0 : tick_r + 16'h1;
    end
  end
  assign tick_evt = (tick_r == TICK_LAST);

  // Sticky events: set wins over write-one-to-clear
  always_ff @(posedge core_clk) begin
    if (srst) begin
      istat_r <= 5'h0;
    end else begin
      istat_r <= (istat_r & ~((wr_go && aw_addr_r == `TMRFD_A_ISTAT && w_strb_r[0])
                              ? w_data_r[4:0] : 5'h0))
                 | {tick_evt, flt_evt};
    end
  end

  // Level interrupt
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(istat_r & imask_r);
    end
  end

  // Write path: address and data taken in either order
  assign wr_go  = aw_got_r && w_got_r && !s_axi_bvalid;
  assign wr_hit = (aw_addr_r[7:2] <= `TMRFD_A_THR3 >> 2) && (aw_addr_r[1:0] == 2'h0)
                  && (aw_addr_r != `TMRFD_A_STATUS) && !(aw_addr_r > `TMRFD_A_IMASK
                  && aw_addr_r < `TMRFD_A_THR0);
  assign wmask  = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};

  always_ff @(posedge core_clk) begin
    if (srst) begin
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      aw_addr_r     <= 8'h0;
      w_data_r      <= 32'h0;
      w_strb_r      <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `TMRFD_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r  <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r  <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `TMRFD_RESP_OKAY : `TMRFD_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !aw_got_r && !srst;
  assign s_axi_wready  = !w_got_r && !srst;

  // Configuration registers written by software
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl_r  <= `TMRFD_RST_CTRL;
      flen_r  <= `TMRFD_RST_FLEN;
      imask_r <= 5'h0;
      for (int i = 0; i < 4; i++) begin
        thr_mem[i] <= '0;
      end
    end else if (wr_go) begin
      case (aw_addr_r)
        `TMRFD_A_CTRL:  ctrl_r  <= 7'((ctrl_r & ~wmask[6:0])
                                      | (w_data_r[6:0] & wmask[6:0]));
        `TMRFD_A_FLEN:  flen_r  <= w_strb_r[0] ? w_data_r[3:0] : flen_r;
        `TMRFD_A_IMASK: imask_r <= w_strb_r[0] ? w_data_r[4:0] : imask_r;
        default: begin
          // Misaligned threshold addresses answer SLVERR and must not write
          if (aw_addr_r >= `TMRFD_A_THR0 && aw_addr_r <= `TMRFD_A_THR3
              && aw_addr_r[1:0] == 2'h0) begin
            thr_mem[aw_addr_r[3:2]] <= 16'((thr_mem[aw_addr_r[3:2]] & ~wmask[15:0])
                                           | (w_data_r[15:0] & wmask[15:0]));
          end
        end
      endcase
    end
  end

  // Read decode
  always_comb begin
    rd_val = 32'h0;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `TMRFD_A_CTRL:   rd_val = {25'h0, ctrl_r};
      `TMRFD_A_FLEN:   rd_val = {28'h0, flen_r};
      `TMRFD_A_RAILEN: rd_val = {28'h0, rail_en_r};
      `TMRFD_A_STATUS: rd_val = {10'h0, idx_r, pgood_r, fault_ov_r, fault_uv_r, 4'h0, state_r};
      `TMRFD_A_ISTAT:  rd_val = {27'h0, istat_r};
      `TMRFD_A_IMASK:  rd_val = {27'h0, imask_r};
      default: begin
        if (s_axi_araddr >= `TMRFD_A_THR0 && s_axi_araddr <= `TMRFD_A_THR3
            && s_axi_araddr[1:0] == 2'h0) begin
          rd_val = {16'h0, thr_mem[s_axi_araddr[3:2]]};
        end else begin
          rd_hit = 1'b0;
        end
      end
    endcase
  end

  // Read answer one cycle after the address is taken
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `TMRFD_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= rd_hit ? `TMRFD_RESP_OKAY : `TMRFD_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid && !srst;

  // Drive outputs from their flops
  assign mux_en   = mux_en_r;
  assign mux_sel  = mux_sel_r;
  assign dac_uv   = dac_uv_r;
  assign dac_ov   = dac_ov_r;
  assign dac_load = dac_load_r;
  assign rail_en  = rail_en_r;
  assign pgood    = pgood_r;
  assign fault_uv = fault_uv_r;
  assign fault_ov = fault_ov_r;
  assign irq      = irq_r;

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  tmrfd_thr_s cur_thr;
  assign cur_thr = thr_mem[idx_r];

  a_mux_select: assert property (state_r == ST_SELECT
                                 |=> mux_en_r && mux_sel_r == $past(idx_r))
    else $error("mux not routed at slot start");
  a_dac_from_mem: assert property (state_r == ST_LOAD |=> dac_load_r
                                   && dac_uv_r == $past(cur_thr.uv_code)
                                   && dac_ov_r == $past(cur_thr.ov_code))
    else $error("DAC not loaded from threshold memory");
  // Restore to sample: one restore cycle plus the whole settle count
  localparam int SETTLE_PAST = `TMRFD_SETTLE_CYC + 1;
  a_settle_wait: assert property (state_r == ST_SAMPLE
                                  |-> $past(state_r, SETTLE_PAST) == ST_RESTORE)
    else $error("settle interval wrong");
  a_filter_clear: assert property (state_r == ST_SAMPLE && !ov_s
                                   |=> filt_r.ov_cnt == 4'h0)
    else $error("filter count not cleared in window");
  a_filter_trip: assert property (state_r == ST_SAMPLE && ov_s && ctrl_r.ov_en
                                  && flen_r != 4'h0
                                  && filt_r.ov_cnt == flen_r - 4'h1 |=> filt_r.ov_flt)
    else $error("fault not declared after filter length");
  a_save_back: assert property (state_r == ST_SAVE
                                |=> filt_mem[$past(idx_r)] == $past(filt_r) ##1 !mux_en_r)
    else $error("filter not saved or rail not disconnected");
  a_next_rail: assert property (state_r == ST_WAIT && slot_r >= slot_len - 8'h1
                                && ctrl_r.run |=> state_r == ST_SELECT
                                && (idx_r == $past(idx_r) + 2'h1 || idx_r == 2'h0))
    else $error("rail did not advance");
  a_slot_rate: assert property ($rose(dac_load_r) |=> !dac_load_r [*8])
    else $error("DAC reloaded too soon");
  a_rail_off: assert property ((rail_en_r & ~pgood_r) != 4'h0
                               |=> (rail_en_r & ~$past(pgood_r)) == 4'h0)
    else $error("faulted rail not switched off");
  a_pgood_low: assert property ((fault_uv_r | fault_ov_r) != 4'h0
                                |=> (pgood_r & $past(fault_uv_r | fault_ov_r)) == 4'h0)
    else $error("power-good high during fault");
  // Interrupt follows the mask as it stood when the event was stored
  a_tick_evt: assert property (tick_r == TICK_LAST |=> istat_r[`TMRFD_IRQ_TICK]
                               ##1 (irq_r || !$past(imask_r[`TMRFD_IRQ_TICK])))
    else $error("tick event lost");

  c_fault_raised: cover property (flt_evt != 4'h0);
  c_rail_wrap:    cover property (state_r == ST_SELECT && idx_r == 2'h3);
  c_irq_high:     cover property ($rose(irq_r));

endmodule : tmrfd_top

`default_nettype wire

// File: test/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "tmrfd_cfg.svh"

module tb;
  localparam int TICK = 400;
  localparam logic [1:0] OK = `TMRFD_RESP_OKAY;
  localparam logic [1:0] ER = `TMRFD_RESP_SLVERR;
  // Stimulus; bready, rready and wstrb stay tied
  logic core_clk = 1'b0, srst = 1'b1, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  // Design outputs
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic mux_en, dac_load, irq, cmp_ov, cmp_uv;
  logic [1:0] s_axi_bresp, s_axi_rresp, mux_sel;
  logic [31:0] s_axi_rdata;
  logic [7:0] dac_uv, dac_ov;
  logic [3:0] rail_en, pgood, fault_uv, fault_ov;
  // Reference model state
  logic [3:0][7:0] volt = {4{8'h80}};
  logic [7:0] tuv[4], tov[4], vl;
  logic [6:0] mctrl = 7'h1e;
  logic [3:0] mfo = 4'h0, mfu = 4'h0;
  logic [1:0] sel;
  logic prev_en = 1'b0, track = 1'b0;
  int cnto[4], cntu[4], cyc, flen = 8, n_errors = 0, cmp_count = 0, seed, r;

  always #12.5 core_clk = ~core_clk;

  tmrfd_top #(.TICK_CYC(TICK)) u_tmrfd_top (.core_clk, .srst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmp_ov, .cmp_uv, .mux_en, .mux_sel, .dac_uv,
    .dac_ov, .dac_load, .rail_en, .pgood, .fault_uv, .fault_ov, .irq);
  tmrfd_cmp_model u_tmrfd_cmp_model (.core_clk, .mux_en, .mux_sel, .dac_uv, .dac_ov, .volt,
    .cmp_ov, .cmp_uv);

  task automatic conclude;
    if (n_errors == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Write one word; ready is judged at the negedge before the taking edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w, b;
    logic [1:0] rs;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge core_clk);
      aw = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge core_clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    chk("bresp", rs, er);
  endtask : wr

  // Read one word and compare the masked data and the response
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic [1:0] er);
    logic ar, rv;
    logic [31:0] d;
    logic [1:0] rs;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    rv = 1'b0;
    while (!rv) begin
      @(negedge core_clk);
      ar = s_axi_arvalid & s_axi_arready;
      rv = s_axi_rvalid;
      d = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge core_clk);
      if (ar) s_axi_arvalid <= 1'b0;
    end
    chk("rdata", d & m, e);
    chk("rresp", rs, er);
  endtask : rc

  // Change a rail level only while no rail is connected
  task automatic setv(input int k, input logic [7:0] v);
    do @(negedge core_clk); while (mux_en);
    volt[k] = v;
  endtask : setv

  // Slot monitor: order, period, DAC codes and filter outcome per visit
  always @(negedge core_clk) begin
    cyc++;
    if (mux_en && !prev_en) begin
      if (track) begin
        chk("period", cyc, 160);
        chk("rail", mux_sel, 2'((sel == mctrl[6:5]) ? 2'd0 : sel + 2'd1));
        chk("pgood", pgood, 4'(~(mfo | mfu)));
      end
      track = 1'b1;
      cyc = 0;
      sel = mux_sel;
      vl = volt[mux_sel];
    end else if ((cyc == 1 || cyc == 2) && track) begin
      chk("dac_load", dac_load, 1'(cyc == 1));
    end else if (!mux_en && prev_en) begin
      chk("dac_uv", dac_uv, tuv[sel]);
      chk("dac_ov", dac_ov, tov[sel]);
      cnto[sel] = (mctrl[2] && vl > tov[sel]) ? cnto[sel] + 1 : 0;
      cntu[sel] = (mctrl[3] && vl < tuv[sel]) ? cntu[sel] + 1 : 0;
      mfo[sel] = flen != 0 && cnto[sel] >= flen;
      mfu[sel] = flen != 0 && cntu[sel] >= flen;
      chk("fault_ov", fault_ov[sel], mfo[sel]);
      chk("fault_uv", fault_uv[sel], mfu[sel]);
    end
    prev_en = mux_en;
  end

  // Watchdog: the whole sequence needs about 10k cycles
  initial begin
    repeat (40000) @(posedge core_clk);
    n_errors++;
    conclude();
  end

  initial begin
    seed = 41471;
    for (r = 0; r < 4; r++) begin
      tuv[r] = 8'h00;
      tov[r] = 8'h00;
    end
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    rc(`TMRFD_A_CTRL, 32'h1e, 32'h7f, OK);
    rc(`TMRFD_A_FLEN, 32'h8, 32'hf, OK);
    rc(8'h40, 32'h0, 32'hffffffff, ER);
    rc(8'h02, 32'h0, 32'hffffffff, ER);
    wr(`TMRFD_A_STATUS, 32'h0, ER);
    wr(`TMRFD_A_FLEN, 32'h3, OK);
    flen = 3;
    // Stop the sequencer so limits never change under a visit
    wr(`TMRFD_A_CTRL, 32'h1c, OK);
    mctrl = 7'h1c;
    repeat (200) @(posedge core_clk);
    // Random per-rail limits, always a valid window
    for (r = 0; r < 4; r++) begin
      tov[r] = 8'(150 + $unsigned($random(seed)) % 100);
      tuv[r] = 8'(20 + $unsigned($random(seed)) % 80);
      wr(8'(`TMRFD_A_THR0 + 4 * r), {16'h0, tov[r], tuv[r]}, OK);
      rc(8'(`TMRFD_A_THR0 + 4 * r), {16'h0, tov[r], tuv[r]}, 32'hffffffff, OK);
    end
    // Fixed limits for the fault scenarios
    for (r = 0; r < 4; r++) begin
      wr(8'(`TMRFD_A_THR0 + 4 * r), {16'h0, 8'(150 + 25 * r), 8'(40 + 10 * r)}, OK);
      tov[r] = 8'(150 + 25 * r);
      tuv[r] = 8'(40 + 10 * r);
      rc(8'(`TMRFD_A_THR0 + 4 * r), {16'h0, tov[r], tuv[r]}, 32'hffff, OK);
    end
    // A misaligned limit write is refused and leaves the limits alone
    wr(8'h21, 32'hffff, ER);
    rc(`TMRFD_A_THR0, {16'h0, tov[0], tuv[0]}, 32'hffffffff, OK);
    wr(`TMRFD_A_IMASK, 32'hf, OK);
    wr(`TMRFD_A_RAILEN, 32'hf, OK);
    wr(`TMRFD_A_CTRL, 32'h7e, OK);
    mctrl = 7'h7e;
    track = 1'b0;
    rc(`TMRFD_A_RAILEN, 32'hf, 32'hf, OK);
    repeat (1300) @(posedge core_clk);
    // Over-voltage on one rail trips after the filter length
    setv(2, 8'hff);
    repeat (2600) @(posedge core_clk);
    chk("irq", irq, 1'b1);
    rc(`TMRFD_A_ISTAT, 32'h4, 32'hf, OK);
    rc(`TMRFD_A_RAILEN, 32'hb, 32'hf, OK);
    chk("rail_en", rail_en, 32'hb);
    setv(2, 8'h80);
    repeat (1300) @(posedge core_clk);
    wr(`TMRFD_A_ISTAT, 32'hf, OK);
    rc(`TMRFD_A_ISTAT, 32'h0, 32'hf, OK);
    chk("irq", irq, 1'b0);
    wr(`TMRFD_A_RAILEN, 32'hf, OK);
    // Over compare off: only the under-voltage rail may trip; stop before the change
    wr(`TMRFD_A_CTRL, 32'h7c, OK);
    repeat (200) @(posedge core_clk);
    setv(0, 8'h00);
    setv(1, 8'hff);
    wr(`TMRFD_A_CTRL, 32'h7a, OK);
    mctrl = 7'h7a;
    track = 1'b0;
    repeat (3200) @(posedge core_clk);
    rc(`TMRFD_A_ISTAT, 32'h1, 32'hf, OK);
    rc(`TMRFD_A_RAILEN, 32'he, 32'hf, OK);
    chk("rail_en", rail_en, 32'he);
    // Periodic service event
    wr(`TMRFD_A_IMASK, 32'h10, OK);
    wr(`TMRFD_A_ISTAT, 32'h1f, OK);
    repeat (TICK + 10) @(posedge core_clk);
    rc(`TMRFD_A_ISTAT, 32'h10, 32'h10, OK);
    chk("irq", irq, 1'b1);
    conclude();
  end
endmodule : tb

`default_nettype wire

// File: test/tmrfd_cmp_model.sv
`timescale 1ns/10ps
`default_nettype none

module tmrfd_cmp_model (
  // Clock for the idle pattern
  input  wire logic            core_clk,
  // Mux and threshold DACs
  input  wire logic            mux_en,
  input  wire logic [1:0]      mux_sel,
  input  wire logic [7:0]      dac_uv,
  input  wire logic [7:0]      dac_ov,
  // Scaled rail levels, one code per rail
  input  wire logic [3:0][7:0] volt,
  // Window comparator, high = out of window
  output logic                 cmp_ov,
  output logic                 cmp_uv
);
  // Disconnected comparator floats: toggle so no stale level is mistaken for a result
  logic tog_r = 1'b0;
  always @(posedge core_clk) tog_r <= ~tog_r;
  // Compare the selected rail against both limits
  assign cmp_ov = mux_en ? (volt[mux_sel] > dac_ov) : tog_r;
  assign cmp_uv = mux_en ? (volt[mux_sel] < dac_uv) : ~tog_r;
endmodule : tmrfd_cmp_model

`default_nettype wire
